// file: gtu_pkg.sv
// Package for the general timer unit: register map, fields, constants
package gtu_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CORE_CTRL   = 8'h00;
  localparam logic [7:0] OFS_AUXA_CTRL   = 8'h04;
  localparam logic [7:0] OFS_AUXB_CTRL   = 8'h08;
  localparam logic [7:0] OFS_SAUX_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_SCORE_CTRL  = 8'h10;
  localparam logic [7:0] OFS_CORE_CNT    = 8'h14;
  localparam logic [7:0] OFS_AUXA_CNT    = 8'h18;
  localparam logic [7:0] OFS_AUXB_CNT    = 8'h1C;
  localparam logic [7:0] OFS_SAUX_CNT    = 8'h20;
  localparam logic [7:0] OFS_SCORE_CNT   = 8'h24;
  localparam logic [7:0] OFS_CAPTURE_RELOAD_REGISTER      = 8'h28;
  localparam logic [7:0] OFS_STATUS      = 8'h2C;

  // Control word fields (per timer)
  localparam int CTL_MODE_LSB  = 0;   // [1:0] mode
  localparam int CTL_RUN_BIT   = 2;   // run enable
  localparam int CTL_DOWN_BIT  = 3;   // software direction: 1 = down
  localparam int CTL_EXTD_BIT  = 4;   // direction from pin
  localparam int CTL_PRE_LSB   = 5;   // [8:5] prescaler exponent
  localparam int CTL_GLVL_BIT  = 9;   // gate level (1 = high)
  localparam int CTL_CHAIN_BIT = 10;  // clock from toggle latch / chain
  localparam int CTL_TOUT_BIT  = 11;  // toggle latch onto pin
  localparam int CTL_CAP_BIT   = 12;  // aux: capture core timer
  localparam int CTL_REL_BIT   = 13;  // aux: reload core timer
  localparam int CTL_RPIN_BIT  = 14;  // reload on pin edge
  localparam int CTL_RTRS_BIT  = 15;  // reload on latch transition
  localparam int CTL_RLVL_BIT  = 16;  // latch transition: 1 = rising
  localparam int CTL_EDG_LSB   = 17;  // [18:17] edge select
  localparam int CTL_CLR_BIT   = 19;  // second aux: clear on capture
  localparam int CTL_CSRC_LSB  = 20;  // [21:20] capture source
  localparam int CTL_CREN_BIT  = 22;  // second core: reload from capreg
  localparam int CTL_WIDTH     = 23;

  // Edge select codes
  localparam logic [1:0] EDG_NONE = 2'h0;
  localparam logic [1:0] EDG_RISE = 2'h1;
  localparam logic [1:0] EDG_FALL = 2'h2;
  localparam logic [1:0] EDG_BOTH = 2'h3;

  // Capture source codes for the capture/reload register
  localparam logic [1:0] CSRC_PIN  = 2'h0;
  localparam logic [1:0] CSRC_CIN  = 2'h1;
  localparam logic [1:0] CSRC_CDIR = 2'h2;
  localparam logic [1:0] CSRC_BOTH = 2'h3;

  // Step pacing in system clocks
  localparam int FIRST_STEP_CYC  = 4;
  localparam int SECOND_STEP_CYC = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timer modes
  typedef enum logic [1:0] {
    GTU_MODE_TIMER = 2'h0,
    GTU_MODE_GATED = 2'h1,
    GTU_MODE_COUNT = 2'h2,
    GTU_MODE_ENC   = 2'h3
  } gtu_mode_t;

  // External pins of one timer
  typedef struct packed {
    logic cnt;   // count / gate / encoder A
    logic dir;   // direction / encoder B
  } gtu_pins_t;

  // Bus slave state
  typedef enum logic [2:0] {
    GTU_ST_IDLE = 3'b001,
    GTU_ST_WRSP = 3'b010,
    GTU_ST_RRSP = 3'b100
  } gtu_bus_st_t;

endpackage : gtu_pkg

// file: gtu_timer_unit.sv
// General timer unit: five 16-bit timers with AXI4-Lite registers
// What this block does
// - five 16-bit up/down timers: core, two aux, second aux, second core.
// - each aux timer runs alone or chained to the core timer of its module.
// - first-module timers choose timer, gated, counter or encoder mode.
// - timer mode counts system clock through a programmable prescaler.
// - counter mode steps on edges at the timer's input pin.
// - gated mode counts prescaled clocks only while pin at gate level.
// - first-module timers step at most once per 4 clocks.
// - direction comes from a software bit or the direction pin.
// - encoder mode decodes quadrature A/B into count and direction.
// - core timer toggles its latch on each wrap, may drive pin.
// - core toggle latch can clock either auxiliary timer.
// - aux timer as capture or reload register stops counting.
// - capture aux latches core timer on selected input pin edge.
// - reload aux loads core timer on pin edge or latch transition.
// - two reload aux on opposite transitions give free-running PWM.
// - second-module timers step at most once per 2 clocks.
// - second-module timers use prescaler or pins, software or pin direction.
// - second core toggles latch on wrap; latch clocks second aux, pin.
// - second core wrap is offered outward and reloads from capreg.
// - capreg captures second aux on capture pin edge, optional clear.
// - capture trigger may come from core count or direction pin edges.
`timescale 1ns/10ps
`default_nettype none

module gtu_timer_unit
  import gtu_pkg::*;
#(
  parameter int TW = 16,
  parameter int PW = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire gtu_pins_t [4:0]  timer_pins,
  input  wire logic             capture_trigger_input,
  output logic                  core_toggle_output,
  output logic                  second_core_toggle_output,
  output logic                  second_core_wrap_pulse
);

  // Timer index map: 0 aux_a, 1 core, 2 aux_b, 3 second aux, 4 second core
  localparam int IA = 0;
  localparam int IC = 1;
  localparam int IB = 2;
  localparam int I5 = 3;
  localparam int I6 = 4;
  localparam int NT = 5;
  localparam logic [TW-1:0] TMAX = {TW{1'b1}};

  initial begin
    if (TW != 16 || PW < 1 || PW > 4) begin
      $error("gtu_timer_unit: unsupported parameters");
    end
  end

  logic [CTL_WIDTH-1:0] ctl_reg [NT];
  logic [TW-1:0]        cnt_reg [NT];
  logic [TW-1:0]        capture_reload_register_reg;
  logic [NT-1:0]        wrap_flag_reg;
  logic                 latch_reg;
  logic                 slatch_reg;

  // Two-stage synchronisers on all pins
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic [10:0] prev_reg;
  logic [10:0] pin_in;
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      pin_in[2*i]   = timer_pins[i].cnt;
      pin_in[2*i+1] = timer_pins[i].dir;
    end
    pin_in[10] = capture_trigger_input;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else if (clk_en) begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire [10:0] rise = sync2_reg & ~prev_reg;
  wire [10:0] fall = ~sync2_reg & prev_reg;

  // Edge match for a 2-bit select
  function automatic logic edge_hit(input logic [1:0] sel, input logic r,
                                    input logic f);
    edge_hit = (sel == EDG_RISE && r) || (sel == EDG_FALL && f) ||
               (sel == EDG_BOTH && (r || f));
  endfunction : edge_hit

  // Step pacing dividers: first module every 4, second every 2 clocks
  logic [1:0]    pace1_reg;
  logic          pace2_reg;
  logic [15:0]   pre_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pace1_reg <= '0;
      pace2_reg <= 1'b0;
      pre_reg   <= '0;
    end else if (clk_en) begin
      pace1_reg <= (pace1_reg == 2'(FIRST_STEP_CYC - 1)) ? 2'h0
                   : pace1_reg + 2'h1;
      pace2_reg <= ~pace2_reg;
      pre_reg   <= pre_reg + 16'h1;
    end
  end
  wire tick1 = (pace1_reg == 2'(FIRST_STEP_CYC - 1));
  wire tick2 = pace2_reg;

  // Pending input events held until the next pacing slot
  logic [NT-1:0] pend_reg;

  // Per-timer step and direction
  logic [NT-1:0] step;
  logic [NT-1:0] down;
  logic [NT-1:0] ev_now;
  logic [NT-1:0] wrap;
  logic          core_enc_cnt;
  logic          core_enc_down;
  logic          latch_tr;
  logic          slatch_tr;

  always_comb begin
    step = '0;
    down = '0;
    ev_now = '0;
    core_enc_cnt = 1'b0;
    core_enc_down = 1'b0;
    for (int i = 0; i < NT; i++) begin
      logic [CTL_WIDTH-1:0] c;
      logic psel;
      logic slot;
      logic pc;
      logic pd;
      logic enc_any;
      c = ctl_reg[i];
      slot = (i >= I5) ? tick2 : tick1;
      // One slot every 2^n clocks; a mask keeps the select width fixed
      psel = (pre_reg & ((16'h1 << c[CTL_PRE_LSB +: 4]) - 16'h1))
             == 16'h0;
      pc = sync2_reg[2*i];
      pd = sync2_reg[2*i+1];
      enc_any = rise[2*i] | fall[2*i] | rise[2*i+1] | fall[2*i+1];
      // Direction: software bit or pin level
      down[i] = c[CTL_EXTD_BIT] ? (pd ^ c[CTL_DOWN_BIT])
                : c[CTL_DOWN_BIT];
      if (c[CTL_CHAIN_BIT] && i != IC && i != I6) begin
        // Clocked by the core or second core toggle latch
        ev_now[i] = (i == I5) ? slatch_tr : latch_tr;
      end else if (i == I6 || i == I5) begin
        ev_now[i] = (c[CTL_MODE_LSB +: 2] == GTU_MODE_COUNT)
                    ? edge_hit(c[CTL_EDG_LSB +: 2], rise[2*i], fall[2*i])
                    : psel;
      end else begin
        unique case (gtu_mode_t'(c[CTL_MODE_LSB +: 2]))
          GTU_MODE_TIMER: ev_now[i] = psel;
          GTU_MODE_GATED: ev_now[i] = psel &&
                           (pc == c[CTL_GLVL_BIT]);
          GTU_MODE_COUNT: ev_now[i] = edge_hit(c[CTL_EDG_LSB +: 2],
                           rise[2*i], fall[2*i]);
          GTU_MODE_ENC: begin
            ev_now[i] = enc_any;
            // A edge: down when A==B after edge; B edge: down when A!=B
            down[i] = (rise[2*i] | fall[2*i]) ? (pc == pd) : (pc != pd);
          end
        endcase
      end
      if (i == IC) begin
        core_enc_cnt  = ev_now[i];
        core_enc_down = down[i];
      end
      // Capture or reload aux does not count
      if ((i == IA || i == IB) &&
          (c[CTL_CAP_BIT] || c[CTL_REL_BIT])) begin
        ev_now[i] = 1'b0;
      end
      if (c[CTL_RUN_BIT] && (ev_now[i] || pend_reg[i]) && slot) begin
        step[i] = 1'b1;
      end
    end
  end

  // Keep events that land between pacing slots
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NT; i++) begin
        // A stopped timer must not bank events for its next start
        pend_reg[i] <= (step[i] || !ctl_reg[i][CTL_RUN_BIT]) ? 1'b0
                       : (pend_reg[i] | ev_now[i]);
      end
    end
  end

  // Wrap detection on each step
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      wrap[i] = step[i] && (down[i] ? (cnt_reg[i] == '0)
                                    : (cnt_reg[i] == TMAX));
    end
  end

  // Latch transitions one cycle after a wrap
  logic latch_d_reg;
  logic slatch_d_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg    <= 1'b0;
      slatch_reg   <= 1'b0;
      latch_d_reg  <= 1'b0;
      slatch_d_reg <= 1'b0;
    end else if (clk_en) begin
      if (wrap[IC]) latch_reg <= ~latch_reg;
      if (wrap[I6]) slatch_reg <= ~slatch_reg;
      latch_d_reg  <= latch_reg;
      slatch_d_reg <= slatch_reg;
    end
  end
  assign latch_tr  = latch_reg ^ latch_d_reg;
  assign slatch_tr = slatch_reg ^ slatch_d_reg;
  wire latch_rise = latch_tr & latch_reg;

  // Capture and reload triggers
  logic cap_a;
  logic cap_b;
  logic rel_a;
  logic rel_b;
  logic cap_s;
  always_comb begin
    logic [CTL_WIDTH-1:0] ca;
    logic [CTL_WIDTH-1:0] cb;
    logic [CTL_WIDTH-1:0] cs;
    logic trs_a;
    logic trs_b;
    ca = ctl_reg[IA];
    cb = ctl_reg[IB];
    cs = ctl_reg[I5];
    trs_a = latch_tr && (latch_rise == ca[CTL_RLVL_BIT]);
    trs_b = latch_tr && (latch_rise == cb[CTL_RLVL_BIT]);
    cap_a = ca[CTL_CAP_BIT] &&
            edge_hit(ca[CTL_EDG_LSB +: 2], rise[2*IA], fall[2*IA]);
    cap_b = cb[CTL_CAP_BIT] &&
            edge_hit(cb[CTL_EDG_LSB +: 2], rise[2*IB], fall[2*IB]);
    rel_a = ca[CTL_REL_BIT] && ((ca[CTL_RPIN_BIT] &&
            edge_hit(ca[CTL_EDG_LSB +: 2], rise[2*IA], fall[2*IA])) ||
            (ca[CTL_RTRS_BIT] && trs_a));
    rel_b = cb[CTL_REL_BIT] && ((cb[CTL_RPIN_BIT] &&
            edge_hit(cb[CTL_EDG_LSB +: 2], rise[2*IB], fall[2*IB])) ||
            (cb[CTL_RTRS_BIT] && trs_b));
    unique case (cs[CTL_CSRC_LSB +: 2])
      CSRC_PIN:  cap_s = edge_hit(cs[CTL_EDG_LSB +: 2], rise[10],
                                  fall[10]);
      CSRC_CIN:  cap_s = rise[2*IC] | fall[2*IC];
      CSRC_CDIR: cap_s = rise[2*IC+1] | fall[2*IC+1];
      CSRC_BOTH: cap_s = rise[2*IC] | fall[2*IC] |
                         rise[2*IC+1] | fall[2*IC+1];
    endcase
  end

  // Bus write decode
  logic          wr_fire;
  logic [7:0]    wr_addr_reg;
  logic [31:0]   wr_data_reg;
  logic          aw_got_reg;
  logic          w_got_reg;

  // Timer counters, capture and reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NT; i++) cnt_reg[i] <= '0;
      capture_reload_register_reg <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NT; i++) begin
        if (step[i]) begin
          cnt_reg[i] <= down[i] ? cnt_reg[i] - 16'h1
                                : cnt_reg[i] + 16'h1;
        end
      end
      if (cap_a) cnt_reg[IA] <= cnt_reg[IC];
      if (cap_b) cnt_reg[IB] <= cnt_reg[IC];
      if (rel_a) cnt_reg[IC] <= cnt_reg[IA];
      else if (rel_b) cnt_reg[IC] <= cnt_reg[IB];
      if (wrap[I6] && ctl_reg[I6][CTL_CREN_BIT]) begin
        cnt_reg[I6] <= capture_reload_register_reg;
      end
      if (cap_s) begin
        capture_reload_register_reg <= cnt_reg[I5];
        if (ctl_reg[I5][CTL_CLR_BIT]) cnt_reg[I5] <= '0;
      end
      if (wr_fire) begin
        for (int i = 0; i < NT; i++) begin
          if (wr_addr_reg == OFS_CORE_CNT + 8'(4 * i)) begin
            cnt_reg[i == 0 ? IC : i == 1 ? IA : i] <= wr_data_reg[TW-1:0];
          end
        end
        if (wr_addr_reg == OFS_CAPTURE_RELOAD_REGISTER) capture_reload_register_reg <= wr_data_reg[TW-1:0];
      end
    end
  end

  // Sticky wrap flags, set beats write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag_reg <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NT; i++) begin
        if (wrap[i]) wrap_flag_reg[i] <= 1'b1;
        else if (wr_fire && wr_addr_reg == OFS_STATUS &&
                 wr_data_reg[i]) wrap_flag_reg[i] <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NT; i++) ctl_reg[i] <= '0;
    end else if (clk_en && wr_fire) begin
      if (wr_addr_reg == OFS_CORE_CTRL)  ctl_reg[IC] <= wr_data_reg[CTL_WIDTH-1:0];
      if (wr_addr_reg == OFS_AUXA_CTRL)  ctl_reg[IA] <= wr_data_reg[CTL_WIDTH-1:0];
      if (wr_addr_reg == OFS_AUXB_CTRL)  ctl_reg[IB] <= wr_data_reg[CTL_WIDTH-1:0];
      if (wr_addr_reg == OFS_SAUX_CTRL)  ctl_reg[I5] <= wr_data_reg[CTL_WIDTH-1:0];
      if (wr_addr_reg == OFS_SCORE_CTRL) ctl_reg[I6] <= wr_data_reg[CTL_WIDTH-1:0];
    end
  end

  // Outputs to pins, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_toggle_output        <= 1'b0;
      second_core_toggle_output <= 1'b0;
      second_core_wrap_pulse    <= 1'b0;
    end else if (clk_en) begin
      core_toggle_output <= ctl_reg[IC][CTL_TOUT_BIT] & latch_reg;
      second_core_toggle_output <= ctl_reg[I6][CTL_TOUT_BIT]
                                   & slatch_reg;
      second_core_wrap_pulse <= wrap[I6];
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  gtu_bus_st_t st_reg;
  logic [1:0]  bresp_reg;
  assign s_axi_awready = (st_reg == GTU_ST_IDLE) && !aw_got_reg;
  assign s_axi_wready  = (st_reg == GTU_ST_IDLE) && !w_got_reg;
  assign s_axi_arready = (st_reg == GTU_ST_IDLE) && !aw_got_reg && !w_got_reg;
  assign s_axi_bvalid  = (st_reg == GTU_ST_WRSP);
  assign s_axi_rvalid  = (st_reg == GTU_ST_RRSP);
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = (st_reg == GTU_ST_IDLE) && aw_got_reg && w_got_reg;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction : mapped

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg      <= GTU_ST_IDLE;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      bresp_reg   <= RESP_OKAY;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      unique case (st_reg)
        GTU_ST_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg  <= 1'b1;
            wr_addr_reg <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg   <= 1'b1;
            wr_data_reg <= s_axi_wdata;
          end
          if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bresp_reg  <= mapped(wr_addr_reg) ? RESP_OKAY : RESP_SLVERR;
            st_reg     <= GTU_ST_WRSP;
          end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= '0;
            unique case (s_axi_araddr)
              OFS_CORE_CTRL:  s_axi_rdata <= 32'(ctl_reg[IC]);
              OFS_AUXA_CTRL:  s_axi_rdata <= 32'(ctl_reg[IA]);
              OFS_AUXB_CTRL:  s_axi_rdata <= 32'(ctl_reg[IB]);
              OFS_SAUX_CTRL:  s_axi_rdata <= 32'(ctl_reg[I5]);
              OFS_SCORE_CTRL: s_axi_rdata <= 32'(ctl_reg[I6]);
              OFS_CORE_CNT:   s_axi_rdata <= 32'(cnt_reg[IC]);
              OFS_AUXA_CNT:   s_axi_rdata <= 32'(cnt_reg[IA]);
              OFS_AUXB_CNT:   s_axi_rdata <= 32'(cnt_reg[IB]);
              OFS_SAUX_CNT:   s_axi_rdata <= 32'(cnt_reg[I5]);
              OFS_SCORE_CNT:  s_axi_rdata <= 32'(cnt_reg[I6]);
              OFS_CAPTURE_RELOAD_REGISTER:     s_axi_rdata <= 32'(capture_reload_register_reg);
              OFS_STATUS:     s_axi_rdata <= 32'({slatch_reg, latch_reg,
                                                  wrap_flag_reg});
              default:        s_axi_rdata <= '0;
            endcase
            st_reg <= GTU_ST_RRSP;
          end
        end
        GTU_ST_WRSP: if (s_axi_bready) st_reg <= GTU_ST_IDLE;
        GTU_ST_RRSP: if (s_axi_rready) st_reg <= GTU_ST_IDLE;
        default: st_reg <= GTU_ST_IDLE;
      endcase
    end
  end

  wire unused_ok = &{1'b0, s_axi_wstrb, core_enc_cnt, core_enc_down};

endmodule : gtu_timer_unit

`default_nettype wire

// file: gtu_timer_unit_properties.sv
// Checker of bus timing and timer outputs of the general timer unit
`timescale 1ns/10ps
`default_nettype none
module gtu_timer_unit_properties
  import gtu_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        core_toggle_output,
  input wire logic        second_core_toggle_output,
  input wire logic        second_core_wrap_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read take, and a flag for an unmapped or unaligned read address
  wire ar_go  = clk_en && s_axi_arvalid && s_axi_arready;
  wire ar_bad = s_axi_araddr > OFS_STATUS || s_axi_araddr[1:0] != 2'h0;
  // Answers stand until the master takes them
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  r_answer_a: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer late");
  w_answer_a: assert property (clk_en && s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  r_refuse_a: assert property (ar_go && ar_bad |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  r_okay_a: assert property (ar_go && !ar_bad |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  // Step pacing seen on the wrap and latch outputs
  wrap_single_a: assert property (second_core_wrap_pulse |=>
    !second_core_wrap_pulse) else $error("wrap pulse too long");
  core_pace_a: assert property ($changed(core_toggle_output) |=>
    $stable(core_toggle_output) [*3]) else $error("core latch too fast");
  second_pace_a: assert property ($changed(second_core_toggle_output)
    |=> $stable(second_core_toggle_output)) else $error("latch too fast");
  c_write_c: cover property (s_axi_bvalid && s_axi_bready);
  c_refuse_c: cover property (ar_go && ar_bad);
  c_wrap_c: cover property (second_core_wrap_pulse);
endmodule : gtu_timer_unit_properties
`default_nettype wire

// file: gtu_pin_model.sv
// Model of the sensors driving the timer pins
`timescale 1ns/10ps
`default_nettype none
module gtu_pin_model
  import gtu_pkg::*;
(
  input  wire logic            aclk,
  output var  gtu_pins_t [4:0] pins,
  output var  logic            cap_in
);
  initial begin
    pins = '0;
    cap_in = 1'b0;
  end
  // Each level held 8 clocks, past synchroniser and step slot
  task automatic pulse(input int idx);
    repeat (2) begin
      @(posedge aclk);
      pins[idx].cnt <= ~pins[idx].cnt;
      repeat (7) @(posedge aclk);
    end
  endtask : pulse
  // Capture pin held high 8 clocks, then released low
  task automatic cap_pulse();
    @(posedge aclk);
    cap_in <= 1'b1;
    repeat (8) @(posedge aclk);
    cap_in <= 1'b0;
  endtask : cap_pulse
  task automatic set_dir(input int idx, input logic d);
    @(posedge aclk);
    pins[idx].dir <= d;
  endtask : set_dir
endmodule : gtu_pin_model
`default_nettype wire

// file: tb.sv
// Self-checking bench of the general timer unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gtu_pkg::*;
  logic            aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]      awaddr = '0, araddr = '0;
  logic [31:0]     wdata = '0, rdata, e;
  logic            awvalid = 0, wvalid = 0, bready = 0;
  logic            arvalid = 0, rready = 0, ce = 1'b1;
  logic            awready, wready, bvalid, arready, rvalid, tout, stout, wrap;
  logic [1:0]      bresp, rresp;
  gtu_pins_t [4:0] pins;
  logic            cap;
  logic [15:0]     v;
  int              n_errors = 0, cmp_count = 0, n, n_wrap = 0;
  gtu_timer_unit i_gtu_timer_unit (.aclk(aclk), .aresetn(aresetn),
    .clk_en(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_pins(pins), .capture_trigger_input(cap),
    .core_toggle_output(tout), .second_core_toggle_output(stout),
    .second_core_wrap_pulse(wrap));
  gtu_pin_model i_gtu_pin_model (.aclk(aclk), .pins(pins), .cap_in(cap));
  always #5 aclk = ~aclk;
  // Second core wrap pulses seen at the pin
  always @(posedge aclk) n_wrap += (wrap === 1'b1);
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  // Write; each channel released once taken, bready held to the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  // Read and compare data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
                     input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, x);
    chk({30'h0, rresp}, {30'h0, r});
    rready <= 1'b0;
  endtask : rdc
  function automatic logic [31:0] ctl(input logic [1:0] m, logic [31:0] b);
    return {30'h0, m} | 32'h1 << CTL_RUN_BIT | b;
  endfunction : ctl
  function automatic logic [31:0] stepv(input logic [15:0] s, input int k);
    return {16'h0, s + k[15:0]};
  endfunction : stepv
  // Main sequence; under 550 clocks in all
  initial begin
    void'($urandom(32'h331E));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 12; i++) rdc(8'(i * 4), 32'h0, RESP_OKAY);
    rdc(8'h30, 32'h0, RESP_SLVERR);
    rdc(8'h06, 32'h0, RESP_SLVERR);
    $display("test reset done");
    // Random start kept clear of wrap both ways
    v = 16'h0100 + 16'($urandom_range(0, 16'hF000));
    n = $urandom_range(2, 6);
    e = EDG_RISE << CTL_EDG_LSB | 32'h1 << CTL_TOUT_BIT;
    wr(OFS_CORE_CNT, {16'h0, v});
    wr(OFS_CORE_CTRL, ctl(GTU_MODE_COUNT, e));
    repeat (n) i_gtu_pin_model.pulse(1);
    repeat (20) @(posedge aclk);
    rdc(OFS_CORE_CNT, stepv(v, n), RESP_OKAY);
    i_gtu_pin_model.set_dir(1, 1'b1);
    wr(OFS_CORE_CTRL, ctl(GTU_MODE_COUNT, e | 32'h1 << CTL_EXTD_BIT));
    repeat (n) i_gtu_pin_model.pulse(1);
    repeat (20) @(posedge aclk);
    rdc(OFS_CORE_CNT, {16'h0, v}, RESP_OKAY);
    i_gtu_pin_model.set_dir(1, 1'b0);
    wr(OFS_CORE_CNT, 32'hFFFE);
    repeat (3) i_gtu_pin_model.pulse(1);
    repeat (20) @(posedge aclk);
    rdc(OFS_CORE_CNT, stepv(16'hFFFE, 3), RESP_OKAY);
    chk({31'h0, tout}, 32'h1);
    $display("test counter done");
    wr(OFS_AUXA_CTRL, 32'h1 << CTL_CAP_BIT | EDG_RISE << CTL_EDG_LSB);
    i_gtu_pin_model.pulse(0);
    repeat (20) @(posedge aclk);
    rdc(OFS_AUXA_CNT, 32'h1, RESP_OKAY);
    // Stopped second aux captured on the capture pin, then cleared
    wr(OFS_SAUX_CNT, {16'h0, v});
    wr(OFS_SAUX_CTRL, EDG_RISE << CTL_EDG_LSB | 32'h1 << CTL_CLR_BIT);
    i_gtu_pin_model.cap_pulse();
    repeat (8) @(posedge aclk);
    rdc(OFS_CAPTURE_RELOAD_REGISTER, {16'h0, v}, RESP_OKAY);
    rdc(OFS_SAUX_CNT, 32'h0, RESP_OKAY);
    $display("test capture done");
    wr(OFS_SCORE_CNT, 32'hFFFF);
    wr(OFS_SCORE_CTRL, ctl(GTU_MODE_TIMER, 32'h1 << CTL_TOUT_BIT));
    repeat (20) @(posedge aclk);
    chk({31'h0, stout}, 32'h1);
    chk(n_wrap, 32'h1);
    rdc(OFS_STATUS, 32'h72, RESP_OKAY);
    wr(OFS_STATUS, 32'h12);
    rdc(OFS_STATUS, 32'h60, RESP_OKAY);
    $display("test second module done");
    // Frozen enable hides a whole pin pulse from the core counter
    ce <= 1'b0;
    i_gtu_pin_model.pulse(1);
    ce <= 1'b1;
    rdc(OFS_CORE_CNT, 32'h1, RESP_OKAY);
    $display("test enable done");
    finish_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
endmodule : tb
bind gtu_timer_unit gtu_timer_unit_properties i_gtu_timer_unit_properties (.*);
`default_nettype wire
